// ===== hw/asrs_fifo.sv
// small synchronous fifo with valid/ready on both sides.
// assumes one clock; clr empties it at once and wins over a push.
`timescale 1ns/1ps

module asrs_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   // clock, reset, enable, flush
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             en,
   input  wire logic             clr,
   // filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

   logic [WIDTH-1:0] mem [0:DEPTH-1];   // storage
   logic [AW-1:0]    wr_ptr;            // next slot to fill
   logic [AW-1:0]    rd_ptr;            // oldest word
   logic [AW:0]      count;             // words held

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;
   // pointers wrap by hand so a depth that is no power of two still works
   wire [AW-1:0] wr_inc = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
   wire [AW-1:0] rd_inc = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);

   assign in_ready  = (count != FULL_CNT);
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   // ----------------------------------------------------------------------
   // storage write
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (en && push)
         mem[wr_ptr] <= in_data;
   end

   // ----------------------------------------------------------------------
   // pointers and count
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (en) begin
         if (clr) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
         end else begin
            if (push)
               wr_ptr <= wr_inc;
            if (pop)
               rd_ptr <= rd_inc;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
         end
      end
   end

endmodule

// ===== hw/asrs_pkg.sv
// types and decode helpers shared by the serial port and ready logic.
// assumes the constants header is on the include path.
`include "asrs_regs.svh"

package asrs_pkg;

   typedef logic [`ASRS_WORD_MSB:0] asrs_word_t;   // one register word
   typedef logic [3:0]              asrs_sel_t;    // register select

   // phase of a serial frame
   typedef enum logic [1:0] {
      ASRS_PH_COMM  = 2'b00,
      ASRS_PH_WRITE = 2'b01,
      ASRS_PH_READ  = 2'b10
   } asrs_phase_e;

   // state behind the ready pin
   typedef enum logic [1:0] {
      ASRS_RS_EMPTY  = 2'b00,
      ASRS_RS_VALID  = 2'b01,
      ASRS_RS_UPDATE = 2'b10,
      ASRS_RS_CAL    = 2'b11
   } asrs_rdy_e;

   // length in bits of a transfer to or from the selected register
   function automatic logic [4:0] asrs_reg_len(input asrs_sel_t sel);
      logic [4:0] len;
      len = `ASRS_LEN_WORD;
      if (sel == `ASRS_SEL_MODE)
         len = `ASRS_LEN_HALF;
      else if (sel == `ASRS_SEL_COMM || sel == `ASRS_SEL_STATUS || sel == `ASRS_SEL_DAC)
         len = `ASRS_LEN_BYTE;
      return len;
   endfunction

   // registers that the host may write
   function automatic logic asrs_writable(input asrs_sel_t sel);
      return (sel >= `ASRS_SEL_MODE) && (sel <= `ASRS_SEL_TEST);
   endfunction

endpackage

// ===== hw/asrs_regs.svh
// named constants of the serial port and ready logic: register selects,
// field positions, transfer lengths, reset values and timing counts.
// assumes it is included by bare name wherever a constant is needed.
`ifndef ASRS_REGS_SVH
`define ASRS_REGS_SVH

// ----------------------------------------------------------------------
// register select codes (communications register, bits 3..0)
// ----------------------------------------------------------------------
`define ASRS_SEL_COMM       4'h0
`define ASRS_SEL_STATUS     4'h1
`define ASRS_SEL_DATA       4'h2
`define ASRS_SEL_MODE       4'h3
`define ASRS_SEL_FILTER     4'h4
`define ASRS_SEL_DAC        4'h5
`define ASRS_SEL_OFFSET     4'h6
`define ASRS_SEL_GAIN       4'h7
`define ASRS_SEL_TEST       4'h8
`define ASRS_NUM_REGS       9

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ASRS_COMM_RD_BIT    6
`define ASRS_COMM_SEL_MSB   3
`define ASRS_COMM_SEL_LSB   0
`define ASRS_MODE_CAL_MSB   15
`define ASRS_MODE_CAL_LSB   13
`define ASRS_WORD_MSB       23

// ----------------------------------------------------------------------
// transfer lengths in bits, reset values, counts
// ----------------------------------------------------------------------
`define ASRS_LEN_BYTE       5'h08
`define ASRS_LEN_HALF       5'h10
`define ASRS_LEN_WORD       5'h18
`define ASRS_ONES_RESET     6'h20
`define ASRS_RESET_WORD     24'h000000
`define ASRS_STAT_PAD       5'h00
`define ASRS_WORD_PAD       16'h0000
`define ASRS_CAL_CYCLES     11'h400
`define ASRS_UPD_HOLD       11'h004
`define ASRS_FIFO_DEPTH     8
`define ASRS_FIFO_WIDTH     24

`endif

// ===== hw/asrs_sync2.sv
// two flip-flop synchroniser for a group of independent levels.
// assumes each bit is a level or a toggle; a multi-bit word must not
// be passed through it.
`timescale 1ns/1ps

module asrs_sync2 #(
   parameter int WIDTH = 1
) (
   // clock, reset, enable
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             en,
   // levels in and out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;   // first stage, read only by the second

   // ----------------------------------------------------------------------
   // two stages
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else if (en) begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

// ===== hw/asrs_top.sv
// serial host port of a converter: frame logic on the serial clock,
// ready pin and data register on the core clock, sync hold of the filter.
// assumes the host makes the serial clock and keeps select low per frame;
// the filter delivers results on a valid/ready stream.
//
// Overview of operation
// - select is active low; frames only while low
// - select tied low gives a three-wire port
// - continuous or gated serial clock both work
// - sync low holds filter, calibration, modulator reset
// - ready pin reports conversion and calibration status
// - ready low when new result word available
// - ready high after full result word read
// - unread result: ready high before update
// - ready high during calibration, low at end
// - output shift register loaded from selected register
// - input shift register moves into selected register
// - reset pin restores all logic to power-on state
// - thirty-two ones reset the serial interface
`timescale 1ns/1ps
`include "asrs_regs.svh"

module asrs_top (
   // core clock, reset, enable
   input  wire logic                CLK,
   input  wire logic                RESETN,
   input  wire logic                CE,
   // serial link
   input  wire logic                SCLK,
   input  wire logic                CS_N,
   input  wire logic                DIN,
   output logic                     DOUT,
   output logic                     DOUT_OE,
   output logic                     DATA_READY_PIN_N,
   // filter sync
   input  wire logic                SYNC_N,
   output logic                     MOD_HOLD,
   output logic                     FILT_HOLD,
   // filter result stream
   input  wire logic                FILT_VALID,
   input  wire asrs_pkg::asrs_word_t FILT_DATA,
   output logic                     FILT_READY,
   // configuration towards the converter core
   output asrs_pkg::asrs_word_t     MODE_WORD
);
   import asrs_pkg::*;

   // ----------------------------------------------------------------------
   // link domain: frame state
   // ----------------------------------------------------------------------
   asrs_phase_e phase;                   // comm byte, write or read
   asrs_phase_e next_phase;
   logic [4:0]  bit_cnt;                 // bits taken in this phase
   logic [4:0]  next_bit_cnt;
   asrs_sel_t   cur_sel;                 // register of this frame
   asrs_sel_t   next_cur_sel;
   asrs_word_t  sh_in;                   // input shift register
   asrs_word_t  next_sh_in;
   asrs_word_t  sh_out;                  // output shift register
   asrs_word_t  next_sh_out;
   logic [5:0]  ones_cnt;                // run of ones on the data input
   logic [5:0]  next_ones_cnt;
   logic        dout_q;                  // data output bit, falling edge

   // link domain: persistent state
   asrs_word_t  cfg [0:`ASRS_NUM_REGS-1]; // host-written registers
   asrs_sel_t   wr_sel_q;                // register of the last write
   logic        wr_tgl;                  // flips on each register write
   logic        rd_tgl;                  // flips on each full data read
   logic [2:0]  stat_link;               // status levels seen on the link

   // core domain
   asrs_rdy_e   rdy_state;               // state behind the ready pin
   asrs_rdy_e   next_rdy_state;
   logic [10:0] tmr;                     // hold and calibration timer
   logic [10:0] next_tmr;
   asrs_word_t  data_word;               // data register
   logic [2:0]  sync_core;               // sync, write and read toggles
   logic        wr_seen;                 // last write toggle taken
   logic        rd_seen;                 // last read toggle taken
   logic        hold_q;                  // filter held by sync
   logic        ready_n_q;               // ready pin flop
   asrs_word_t  mode_q;                  // core copy of the mode register
   logic        fifo_valid;              // result waiting in the fifo
   asrs_word_t  fifo_data;               // oldest waiting result

   // ----------------------------------------------------------------------
   // link domain: decode
   // ----------------------------------------------------------------------
   // the frame resets whenever select is high, so a frame ends with its own
   // select edge and nothing waits for a serial clock edge after it
   wire        link_rst_n = RESETN & ~CS_N;
   wire [4:0]  bit_inc    = bit_cnt + 5'h01;
   wire [4:0]  cur_len    = asrs_reg_len(cur_sel);
   wire asrs_word_t shift_val = {sh_in[`ASRS_WORD_MSB-1:0], DIN};
   wire [5:0]  ones_inc   = ones_cnt + 6'h01;
   wire        ones_hit   = DIN && (ones_inc == `ASRS_ONES_RESET);
   wire        comm_done  = (phase == ASRS_PH_COMM) && (bit_inc == `ASRS_LEN_BYTE);
   wire        xfer_done  = (phase != ASRS_PH_COMM) && (bit_inc == cur_len);
   wire asrs_sel_t comm_sel = shift_val[`ASRS_COMM_SEL_MSB:`ASRS_COMM_SEL_LSB];
   wire        comm_rd    = shift_val[`ASRS_COMM_RD_BIT];
   wire [4:0]  comm_len   = asrs_reg_len(comm_sel);
   wire        wr_commit  = xfer_done && !ones_hit && (phase == ASRS_PH_WRITE) && asrs_writable(cur_sel);
   wire        rd_commit  = xfer_done && !ones_hit && (phase == ASRS_PH_READ) && (cur_sel == `ASRS_SEL_DATA);
   wire [7:0]  status_byte = {stat_link, `ASRS_STAT_PAD};
   wire        cfg_hit    = comm_sel < 4'(`ASRS_NUM_REGS);
   // the data register is read without a handshake: it only changes while
   // the ready pin is high, and the host starts no read then
   wire asrs_word_t rd_src =
      (comm_sel == `ASRS_SEL_DATA)   ? data_word :
      (comm_sel == `ASRS_SEL_STATUS) ? {`ASRS_WORD_PAD, status_byte} :
      cfg_hit                        ? cfg[comm_sel] : `ASRS_RESET_WORD;
   // short registers leave the shifter at its top so the msb goes first
   wire asrs_word_t rd_aligned = rd_src << (`ASRS_LEN_WORD - comm_len);

   // ----------------------------------------------------------------------
   // link domain: next frame state
   // ----------------------------------------------------------------------
   // state moves only on serial clock edges and has no timeout, so a clock
   // that pauses between bursts loses nothing
   always_comb begin
      next_phase    = phase;
      next_bit_cnt  = bit_inc;
      next_cur_sel  = cur_sel;
      next_sh_in    = shift_val;
      next_sh_out   = {sh_out[`ASRS_WORD_MSB-1:0], 1'b0};
      next_ones_cnt = DIN ? ones_inc : 6'h00;
      if (ones_hit) begin
         next_phase    = ASRS_PH_COMM;
         next_bit_cnt  = 5'h00;
         next_cur_sel  = `ASRS_SEL_COMM;
         next_sh_in    = `ASRS_RESET_WORD;
         next_sh_out   = `ASRS_RESET_WORD;
         next_ones_cnt = 6'h00;
      end else if (comm_done) begin
         // comm byte taken: choose register and direction
         next_bit_cnt = 5'h00;
         next_cur_sel = comm_sel;
         next_sh_in   = `ASRS_RESET_WORD;
         if (comm_rd) begin
            next_phase  = ASRS_PH_READ;
            next_sh_out = rd_aligned;
         end else begin
            next_phase  = ASRS_PH_WRITE;
         end
      end else if (xfer_done) begin
         // word done: back to waiting for a comm byte
         next_phase   = ASRS_PH_COMM;
         next_bit_cnt = 5'h00;
         next_sh_in   = `ASRS_RESET_WORD;
      end
   end

   // frame state: rising serial clock edge, the host supplies the clock
   always_ff @(posedge SCLK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         phase    <= ASRS_PH_COMM;
         bit_cnt  <= 5'h00;
         cur_sel  <= `ASRS_SEL_COMM;
         sh_in    <= `ASRS_RESET_WORD;
         sh_out   <= `ASRS_RESET_WORD;
         ones_cnt <= 6'h00;
      end else begin
         phase    <= next_phase;
         bit_cnt  <= next_bit_cnt;
         cur_sel  <= next_cur_sel;
         sh_in    <= next_sh_in;
         sh_out   <= next_sh_out;
         ones_cnt <= next_ones_cnt;
      end
   end

   // data output changes on the falling edge, half a period before sampling
   always_ff @(negedge SCLK or negedge link_rst_n) begin
      if (!link_rst_n)
         dout_q <= 1'b0;
      else
         dout_q <= (phase == ASRS_PH_READ) & sh_out[`ASRS_WORD_MSB];
   end

   assign DOUT    = dout_q;
   assign DOUT_OE = ~CS_N;

   // ----------------------------------------------------------------------
   // link domain: registers and crossing toggles
   // ----------------------------------------------------------------------
   // registers survive select going high; only the reset pin clears them
   always_ff @(posedge SCLK or negedge RESETN) begin
      if (!RESETN) begin
         for (int i = 0; i < `ASRS_NUM_REGS; i++)
            cfg[i] <= `ASRS_RESET_WORD;
         wr_sel_q <= `ASRS_SEL_COMM;
         wr_tgl   <= 1'b0;
         rd_tgl   <= 1'b0;
      end else begin
         if (wr_commit) begin
            cfg[cur_sel] <= shift_val;
            wr_sel_q     <= cur_sel;
            wr_tgl       <= ~wr_tgl;
         end
         if (rd_commit)
            rd_tgl <= ~rd_tgl;
      end
   end

   // status levels into the link domain for status reads
   asrs_sync2 #(
      .WIDTH (3)
   ) u_sync_link (
      .clk   (SCLK),
      .rst_n (RESETN),
      .en    (1'b1),
      .d     ({ready_n_q, rdy_state == ASRS_RS_CAL, hold_q}),
      .q     (stat_link)
   );

   // ----------------------------------------------------------------------
   // core domain: crossings in
   // ----------------------------------------------------------------------
   asrs_sync2 #(
      .WIDTH (3)
   ) u_sync_core (
      .clk   (CLK),
      .rst_n (RESETN),
      .en    (CE),
      .d     ({SYNC_N, wr_tgl, rd_tgl}),
      .q     (sync_core)
   );

   wire sync_low = ~sync_core[2];
   wire wr_evt   = sync_core[1] ^ wr_seen;
   wire rd_evt   = sync_core[0] ^ rd_seen;
   // the written word stays put until the next write, long after the toggle
   wire asrs_word_t wr_word = cfg[wr_sel_q];
   wire mode_wr   = wr_evt && (wr_sel_q == `ASRS_SEL_MODE);
   wire cal_start = mode_wr && (wr_word[`ASRS_MODE_CAL_MSB:`ASRS_MODE_CAL_LSB] != 3'h0);
   wire upd_load  = (rdy_state == ASRS_RS_UPDATE) && (tmr == 11'h000);
   wire [10:0] tmr_dec = tmr - 11'h001;

   // ----------------------------------------------------------------------
   // core domain: result fifo
   // ----------------------------------------------------------------------
   // the fifo drains only into the data register, so during calibration it
   // fills and stalls the filter through its ready; a sync hold clears it
   asrs_fifo #(
      .WIDTH (`ASRS_FIFO_WIDTH),
      .DEPTH (`ASRS_FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLK),
      .rst_n     (RESETN),
      .en        (CE),
      .clr       (hold_q),
      .in_valid  (FILT_VALID),
      .in_ready  (FILT_READY),
      .in_data   (FILT_DATA),
      .out_valid (fifo_valid),
      .out_ready (upd_load),
      .out_data  (fifo_data)
   );

   // ----------------------------------------------------------------------
   // core domain: ready state machine
   // ----------------------------------------------------------------------
   always_comb begin
      next_rdy_state = rdy_state;
      next_tmr       = tmr;
      case (rdy_state)
         ASRS_RS_EMPTY: begin
            if (cal_start) begin
               next_rdy_state = ASRS_RS_CAL;
               next_tmr       = `ASRS_CAL_CYCLES;
            end else if (fifo_valid) begin
               next_rdy_state = ASRS_RS_UPDATE;
               next_tmr       = `ASRS_UPD_HOLD;
            end
         end
         ASRS_RS_VALID: begin
            if (cal_start) begin
               next_rdy_state = ASRS_RS_CAL;
               next_tmr       = `ASRS_CAL_CYCLES;
            end else if (rd_evt) begin
               next_rdy_state = ASRS_RS_EMPTY;
            end else if (fifo_valid) begin
               next_rdy_state = ASRS_RS_UPDATE;
               next_tmr       = `ASRS_UPD_HOLD;
            end
         end
         ASRS_RS_UPDATE: begin
            // ready stays high for the hold, the register changes last
            if (tmr == 11'h000)
               next_rdy_state = ASRS_RS_VALID;
            else
               next_tmr = tmr_dec;
         end
         ASRS_RS_CAL: begin
            if (tmr == 11'h000)
               next_rdy_state = ASRS_RS_VALID;
            else
               next_tmr = tmr_dec;
         end
         default: begin
            next_rdy_state = ASRS_RS_EMPTY;
         end
      endcase
      // a held filter aborts calibration and any pending update
      if (sync_low) begin
         next_rdy_state = ASRS_RS_EMPTY;
         next_tmr       = 11'h000;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rdy_state <= ASRS_RS_EMPTY;
         tmr       <= 11'h000;
         ready_n_q <= 1'b1;
         wr_seen   <= 1'b0;
         rd_seen   <= 1'b0;
         hold_q    <= 1'b1;
      end else if (CE) begin
         rdy_state <= next_rdy_state;
         tmr       <= next_tmr;
         ready_n_q <= (next_rdy_state != ASRS_RS_VALID);
         wr_seen   <= sync_core[1];
         rd_seen   <= sync_core[0];
         hold_q    <= sync_low;
      end
   end

   // ----------------------------------------------------------------------
   // core domain: data register and mode copy
   // ----------------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         data_word <= `ASRS_RESET_WORD;
         mode_q    <= `ASRS_RESET_WORD;
      end else if (CE) begin
         if (upd_load && !sync_low)
            data_word <= fifo_data;
         if (mode_wr)
            mode_q <= wr_word;
      end
   end

   assign DATA_READY_PIN_N = ready_n_q;
   assign MOD_HOLD         = hold_q;
   assign FILT_HOLD        = hold_q;
   assign MODE_WORD        = mode_q;

endmodule

// ===== test/asrs_host.sv
// host model: gated 48 ns link clock, select low per frame.
`timescale 1ns/1ps
module asrs_host (
   output logic SCLK = 0, CS_N = 0, DIN = 0,
   input wire logic DOUT, DOUT_OE);
   // select starts low so the reset fall also clears the frame logic,
   // then it idles high between frames
   initial #2 CS_N = 1;
   // msb first; clock idles low, a gap splits the burst
   task automatic frame(logic [63:0] w, int n, bit gap, output logic [31:0] r);
      r = '0;
      #7 CS_N = 0;
      for (int i = n - 1; i >= 0; i--) begin
         DIN = w[i];
         #24 SCLK = 1;
         r = {r[30:0], DOUT_OE ? DOUT : 1'b1};
         #24 SCLK = 0;
         if (gap && i == n / 2) #300;
      end
      #24 CS_N = 1;
      DIN = ~DIN; // released line keeps no stale bit
   endtask
endmodule

// ===== test/asrs_top_sva.sv
// assertions on the asrs_top ports, bound at the foot.
`timescale 1ns/1ps
module asrs_top_sva (
   input wire logic CLK, RESETN, CE, SCLK, CS_N, DIN, DOUT, DOUT_OE, DATA_READY_PIN_N,
   input wire logic SYNC_N, MOD_HOLD, FILT_HOLD, FILT_VALID, FILT_READY,
   input wire asrs_pkg::asrs_word_t FILT_DATA, MODE_WORD);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   property p_oe; DOUT_OE == !CS_N; endproperty
   a_oe: assert property (p_oe) else $error("enable off");
   property p_idle; CS_N [*2] |-> !DOUT; endproperty
   a_idle: assert property (p_idle) else $error("out idle");
   property p_hold; !SYNC_N [*5] |-> MOD_HOLD && FILT_HOLD; endproperty
   a_hold: assert property (p_hold) else $error("no hold");
   property p_flush; !SYNC_N [*6] |-> DATA_READY_PIN_N && FILT_READY; endproperty
   a_flush: assert property (p_flush) else $error("no flush");
   property p_free; SYNC_N [*8] |-> !FILT_HOLD; endproperty
   a_free: assert property (p_free) else $error("stuck hold");
   property p_upd; $fell(DATA_READY_PIN_N) |-> $past(DATA_READY_PIN_N, 4); endproperty
   a_upd: assert property (p_upd) else $error("short update");
   property p_cal; $changed(MODE_WORD) && MODE_WORD[15:13] != 0 |-> ##[0:4] DATA_READY_PIN_N [*8]; endproperty
   a_cal: assert property (p_cal) else $error("no cal busy");
   property p_rst; $rose(RESETN) |-> DATA_READY_PIN_N && FILT_HOLD && MODE_WORD == 0; endproperty
   a_rst: assert property (p_rst) else $error("bad reset");
endmodule
bind asrs_top asrs_top_sva i_sva (.*);

// ===== test/asrs_top_test.sv
// bench of asrs_top: host model on the link, stream and sync here.
`timescale 1ns/1ps
`include "asrs_regs.svh"
module asrs_top_test;
   // reset starts high so that its first fall is a real edge for the async resets
   logic CLK = 0, RESETN = 1, SYNC_N = 1, FILT_VALID = 0, CE = 1;
   logic SCLK, CS_N, DIN, DOUT, DOUT_OE, DATA_READY_PIN_N, MOD_HOLD, FILT_HOLD, FILT_READY;
   asrs_pkg::asrs_word_t FILT_DATA = '0, MODE_WORD;
   logic [31:0] r;
   int failures = 0, compares = 0, cyc = 0, hi_run = 0;
   always #5 CLK = ~CLK;
   // length of the present run of high ready samples, taken at the falling edge
   always @(negedge CLK) hi_run <= DATA_READY_PIN_N ? hi_run + 1 : 0;
   asrs_top i_dut (.*);
   asrs_host i_host (.*);
   task chk(string s, logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task wrap_up;
      $display("%0d compares %0d failures", compares, failures);
      if (failures == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // outputs are read at the falling edge, where they have settled
   task clk(int n); repeat (n) @(negedge CLK); endtask
   task wait_rdy(logic v);
      @(negedge CLK);
      for (int k = 0; k < 2000 && DATA_READY_PIN_N !== v; k++) @(negedge CLK);
      chk("ready", v, DATA_READY_PIN_N);
   endtask
   task push(logic [23:0] w);
      @(posedge CLK) {FILT_VALID, FILT_DATA} <= {1'b1, w};
      // the word stands until an edge at which the fifo shows ready
      do @(posedge CLK); while (FILT_READY !== 1'b1);
      FILT_VALID <= 0;
   endtask
   task t_mode;
      i_host.frame(64'h031234, 24, 1, r);
      clk(10);
      chk("mode", 16'h1234, MODE_WORD[15:0]);
      i_host.frame(60'h0FFFFFFFF430000, 60, 0, r);
      chk("mode read", 16'h1234, r[15:0]);
      $display("mode done");
   endtask
   task t_data;
      push(24'hA5C3E1);
      wait_rdy(0);
      i_host.frame(64'h42000000, 32, 0, r);
      chk("data", 24'hA5C3E1, r[23:0]);
      clk(8);
      chk("ready", 1, DATA_READY_PIN_N);
      push(24'h3C5A96);
      push(24'h0F1E2D);
      clk(20);
      wait_rdy(0);
      i_host.frame(64'h42000000, 32, 0, r);
      chk("data", 24'h0F1E2D, r[23:0]);
      $display("data done");
   endtask
   task t_cal;
      push(24'h5AA55A);
      wait_rdy(0);
      // ready is low first, so the rise can only come from the calibration
      i_host.frame(64'h032000, 24, 0, r);
      wait_rdy(1);
      // 100 frozen edges of the clock enable stretch the busy time as long
      @(posedge CLK) CE <= 0;
      repeat (100) @(posedge CLK);
      CE <= 1;
      while (DATA_READY_PIN_N === 1'b1 && hi_run < 3000) @(negedge CLK);
      chk("cal length", `ASRS_CAL_CYCLES + 101, hi_run);
      chk("cal end", 0, DATA_READY_PIN_N);
      @(posedge CLK) SYNC_N <= 0;
      clk(10);
      chk("sync", 7, {MOD_HOLD, FILT_HOLD, DATA_READY_PIN_N});
      @(posedge CLK) SYNC_N <= 1;
      clk(10);
      chk("hold", 0, {MOD_HOLD, FILT_HOLD});
      $display("cal done");
   endtask
   always @(posedge CLK) if (++cyc == 6000) begin
      failures++;
      wrap_up;
   end
   initial begin
      #1 RESETN <= 0;
      repeat (2) @(posedge CLK);
      RESETN <= 1;
      t_mode;
      t_data;
      t_cal;
      wrap_up;
   end
endmodule
